// ==== hw/isp_pin_filter.sv ====
// Purpose: two-flop synchroniser and spike filter for both bus lines
// Assumes: lines idle high
// Notes:   a line changes only after holding its new level N cycles
`timescale 1ns/1ps
module isp_pin_filter
  import isp_pkg::*;
#(
  parameter int LS_CYC = LS_FILT_CYC,
  parameter int HS_CYC = HS_FILT_CYC
) (
  input  wire logic     clk_sys,
  input  wire logic     rst,
  input  wire logic     hsMode,
  input  wire isp_bus_s busRaw,
  output isp_bus_s      busFilt
);

  // counter must hold the low-speed window; hs window may not be longer
  if (LS_CYC < 1 || HS_CYC < 1 || LS_CYC >= (1 << FILT_CNT_W) || HS_CYC > LS_CYC) begin : gBad
    $error("isp_pin_filter: bad filter lengths");
  end

  logic [1:0] rawVec;
  logic [1:0] filtVec;

  assign rawVec        = {busRaw.scl, busRaw.sda};
  assign busFilt.scl   = filtVec[1];
  assign busFilt.sda   = filtVec[0];

  localparam logic [FILT_CNT_W-1:0] LS_LIM = FILT_CNT_W'(LS_CYC - 1);
  localparam logic [FILT_CNT_W-1:0] HS_LIM = FILT_CNT_W'(HS_CYC - 1);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gLine
      logic                  meta_r, sync_r, out_r, out_nxt;
      logic [FILT_CNT_W-1:0] cnt_r, cnt_nxt, lim;

      // hs mode shortens the window so fast clocks pass
      assign lim = hsMode ? HS_LIM : LS_LIM;

      always_comb begin
        out_nxt = out_r;
        cnt_nxt = '0;
        if (sync_r != out_r) begin
          if (cnt_r >= lim) begin
            out_nxt = sync_r;
          end else begin
            cnt_nxt = cnt_r + FILT_CNT_W'(1);
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          meta_r <= 1'b1;
          sync_r <= 1'b1;
          out_r  <= 1'b1;
          cnt_r  <= '0;
        end else begin
          meta_r <= rawVec[g];
          sync_r <= meta_r;
          out_r  <= out_nxt;
          cnt_r  <= cnt_nxt;
        end
      end

      assign filtVec[g] = out_r;
    end
  endgenerate

endmodule

// ==== hw/isp_pkg.sv ====
// Purpose: shared constants and types for the serial register port
// Assumes: system clock of 125 MHz
// Notes:   filter counts derive from spike widths in ns
package isp_pkg;

  localparam int          CLK_MHZ        = 125;
  localparam logic [6:0]  OWN_ADDR       = 7'h18;  // 0x30 write, 0x31 read
  localparam logic [6:0]  GEN_CALL_ADDR  = 7'h00;
  localparam logic [4:0]  HS_CODE_TOP    = 5'h01;  // master code 00001xxx
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;

  // spike widths rejected by the input filters
  localparam int          LS_SPIKE_NS    = 50;
  localparam int          HS_SPIKE_NS    = 10;
  localparam int          LS_FILT_CYC    = (LS_SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam int          HS_FILT_CYC    = (HS_SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam int          FILT_CNT_W     = 4;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_PTR   = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100
  } isp_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } isp_bus_s;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } isp_wr_s;

endpackage

// ==== hw/isp_slave_port.sv ====
// Purpose: two-wire serial slave giving access to converter registers
// Assumes: external register file answers regRdData for regAddr combinationally
// Notes:   clock line is input only; the port never holds it low
`timescale 1ns/1ps
module isp_slave_port
  import isp_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = OWN_ADDR
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOeN,
  output isp_wr_s         regWr,
  output logic [7:0]      regAddr,
  input  wire logic [7:0] regRdData,
  output logic            hsMode
);

  // a reserved code would make the port answer broadcasts or take its own address for a master code
  if (SLAVE_ADDR == GEN_CALL_ADDR || SLAVE_ADDR[6:2] == HS_CODE_TOP) begin : gBadAddr
    $error("isp_slave_port: reserved slave address");
  end

  isp_bus_s   busRaw;
  isp_bus_s   busF;
  logic       sclPrev_r;
  logic       sdaPrev_r;

  isp_state_e state_r,   state_nxt;
  logic [3:0] bitCnt_r,  bitCnt_nxt;
  logic       ackPh_r,   ackPh_nxt;
  logic [7:0] shift_r,   shift_nxt;
  logic [7:0] tx_r,      tx_nxt;
  logic [7:0] ptr_r,     ptr_nxt;
  logic       oeN_r,     oeN_nxt;
  logic       hs_r,      hs_nxt;
  isp_wr_s    wr_r,      wr_nxt;

  logic       sclRise, sclFall, startEv, stopEv;
  logic       addrHit, hsCode;

  assign busRaw.scl = sclIn;
  assign busRaw.sda = sdaIn;

  // filter window follows hsMode so fast clocks are not swallowed
  isp_pin_filter uFilt (
    .clk_sys (clk_sys),
    .rst     (rst),
    .hsMode  (hs_r),
    .busRaw  (busRaw),
    .busFilt (busF)
  );

  assign sclRise = busF.scl & ~sclPrev_r;
  assign sclFall = ~busF.scl & sclPrev_r;
  // edges of data while clock stays high are framing, not data
  assign startEv = busF.scl & sclPrev_r & sdaPrev_r & ~busF.sda;
  assign stopEv  = busF.scl & sclPrev_r & ~sdaPrev_r & busF.sda;

  // only looked at on the eighth clock fall, when the byte is complete
  assign addrHit = (shift_r[7:1] == SLAVE_ADDR);
  assign hsCode  = (shift_r[7:3] == HS_CODE_TOP);

  always_comb begin
    state_nxt  = state_r;
    bitCnt_nxt = bitCnt_r;
    ackPh_nxt  = ackPh_r;
    shift_nxt  = shift_r;
    tx_nxt     = tx_r;
    ptr_nxt    = ptr_r;
    oeN_nxt    = oeN_r;
    hs_nxt     = hs_r;
    wr_nxt     = wr_r;
    wr_nxt.en  = 1'b0;

    if (startEv) begin
      // repeated start needs no stop first and keeps the filter mode
      state_nxt  = ST_ADDR;
      bitCnt_nxt = '0;
      ackPh_nxt  = 1'b0;
      oeN_nxt    = 1'b1;
    end else if (stopEv) begin
      // a stop always drops the filters back to low speed
      state_nxt  = ST_IDLE;
      ackPh_nxt  = 1'b0;
      oeN_nxt    = 1'b1;
      hs_nxt     = 1'b0;
    end else if (state_r != ST_IDLE) begin
      if (sclRise) begin
        if (!ackPh_r) begin
          shift_nxt  = {shift_r[6:0], busF.sda};
          bitCnt_nxt = bitCnt_r + 4'h1;
        end else if (state_r == ST_WDATA && bitCnt_r == BITS_PER_BYTE) begin
          // data byte lands on the acknowledge clock rise
          wr_nxt.en   = 1'b1;
          wr_nxt.addr = ptr_r;
          wr_nxt.data = shift_r;
          ptr_nxt     = ptr_r + 8'h01;
        end else if (state_r == ST_RDATA && busF.sda) begin
          // master nack ends the read; wait for stop or new start
          state_nxt = ST_IDLE;
          ackPh_nxt = 1'b0;
        end
      end else if (sclFall) begin
        if (!ackPh_r && bitCnt_r == BITS_PER_BYTE) begin
          ackPh_nxt = 1'b1;
          oeN_nxt   = 1'b1;
          case (state_r)
            ST_ADDR: begin
              if (hsCode) begin
                // stay silent; only the filter mode changes
                hs_nxt    = 1'b1;
                state_nxt = ST_IDLE;
              end else if (addrHit) begin
                oeN_nxt   = 1'b0;
                state_nxt = shift_r[0] ? ST_RDATA : ST_PTR;
              end else begin
                // general call and foreign addresses land here
                state_nxt = ST_IDLE;
                ackPh_nxt = 1'b0;
              end
            end
            ST_PTR: begin
              // clear the count so the pointer ack clock is not taken as a data ack
              ptr_nxt    = shift_r;
              bitCnt_nxt = '0;
              oeN_nxt   = 1'b0;
              state_nxt = ST_WDATA;
            end
            ST_WDATA: begin
              oeN_nxt   = 1'b0;
            end
            default: begin
              oeN_nxt   = 1'b1;
            end
          endcase
          if (hsCode && state_r == ST_ADDR) begin
            ackPh_nxt = 1'b0;
          end
        end else if (ackPh_r) begin
          // end of acknowledge clock: release, or drive first read bit
          ackPh_nxt  = 1'b0;
          bitCnt_nxt = '0;
          oeN_nxt    = 1'b1;
          if (state_r == ST_RDATA) begin
            // pointer moves on at once so the next byte is already addressed
            tx_nxt  = regRdData;
            oeN_nxt = regRdData[7];
            ptr_nxt = ptr_r + 8'h01;
          end
        end else if (state_r == ST_RDATA) begin
          // change data only while clock is low
          oeN_nxt = tx_r[3'(4'h7 - bitCnt_r)];
        end
      end
    end
  end

  // edge history starts at the idle level, so no false edge after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      state_r   <= ST_IDLE;
      bitCnt_r  <= '0;
      ackPh_r   <= 1'b0;
      shift_r   <= '0;
      tx_r      <= '0;
      ptr_r     <= '0;
      oeN_r     <= 1'b1;
      hs_r      <= 1'b0;
      wr_r      <= '0;
    end else begin
      sclPrev_r <= busF.scl;
      sdaPrev_r <= busF.sda;
      state_r   <= state_nxt;
      bitCnt_r  <= bitCnt_nxt;
      ackPh_r   <= ackPh_nxt;
      shift_r   <= shift_nxt;
      tx_r      <= tx_nxt;
      ptr_r     <= ptr_nxt;
      oeN_r     <= oeN_nxt;
      hs_r      <= hs_nxt;
      wr_r      <= wr_nxt;
    end
  end

  // open drain: only ever pulls low; clock line has no driver at all
  assign sdaOut  = 1'b0;
  assign sdaOeN  = oeN_r;
  assign regWr   = wr_r;
  assign regAddr = ptr_r;
  assign hsMode  = hs_r;

endmodule

// ==== verification/isp_bus_master.sv ====
// Purpose: behavioural bus master for the serial port
// Assumes: bench resolves open-drain data into sdaLine
// Notes:   clock stands still between frames; Q is a quarter bit
`timescale 1ns/1ps
module isp_bus_master #(
  parameter int Q = 10
) (
  input  wire logic clk_sys,
  input  wire logic sdaLine,
  output logic      sclDrv,
  output logic      sdaDrv
);
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic waitQ();
    repeat (Q) @(posedge clk_sys);
  endtask
  // first wait lets the slave drop its ack before data rises
  task automatic sendStart();
    waitQ();
    sdaDrv <= 1'b1;
    waitQ();
    sclDrv <= 1'b1;
    waitQ();
    sdaDrv <= 1'b0;
    waitQ();
    sclDrv <= 1'b0;
  endtask
  task automatic sendStop();
    waitQ();
    sdaDrv <= 1'b0;
    waitQ();
    sclDrv <= 1'b1;
    waitQ();
    sdaDrv <= 1'b1;
    waitQ();
  endtask
  task automatic bitCycle(input logic b, output logic s);
    waitQ();
    sdaDrv <= b;
    waitQ();
    sclDrv <= 1'b1;
    waitQ();
    s = sdaLine;
    waitQ();
    sclDrv <= 1'b0;
  endtask
  task automatic sendByte(input logic [7:0] d, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) bitCycle(d[i], s);
    bitCycle(1'b1, s);
    acked = (s === 1'b0);
  endtask
  task automatic recvByte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitCycle(1'b1, d[i]);
    bitCycle(last, s);
  endtask
endmodule

// ==== verification/isp_port_checker.sv ====
// Purpose: port-level assertions for the serial slave
// Assumes: pin lines seen raw, before the internal filters
// Notes:   bus clock slow enough to cover filter lag
`timescale 1ns/1ps
module isp_port_checker
  import isp_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOeN,
  input wire isp_wr_s    regWr,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  input wire logic       hsMode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_PULL_LOW_ONLY: assert property (sdaOut == 1'b0)
    else $error("data drive value not low");
  AST_OE_SCL_LOW: assert property ($changed(sdaOeN) |-> !sclIn)
    else $error("data drive changed with clock high");
  AST_OE_RELEASE: assert property ($fell(sdaOeN) |-> ##[1:400] sdaOeN)
    else $error("data line held too long");
  AST_WR_ONE_CYCLE: assert property (regWr.en |=> !regWr.en)
    else $error("write strobe longer than one cycle");
  AST_WR_AT_ACK: assert property (regWr.en |-> sclIn && !sdaOeN)
    else $error("write outside acked clock high");
  AST_PTR_STEP: assert property (regWr.en |=> regAddr == $past(regWr.addr) + 8'h01)
    else $error("pointer did not step");
  AST_HS_STOP: assert property ($fell(hsMode) |-> sclIn && sdaIn)
    else $error("fast filter left without stop");
  AST_HS_NACK: assert property ($rose(hsMode) |-> sdaOeN [*8])
    else $error("master code acknowledged");
  AST_RST_STATE: assert property ($fell(rst) |-> sdaOeN && !hsMode && regAddr == 8'h00)
    else $error("bad state after reset");
endmodule

// ==== verification/isp_slave_port_bench.sv ====
// Purpose: self-checking bench for the serial slave port
// Assumes: pattern register file answers pointer xor 0x5A
// Notes:   bus bit slowed to 40 cycles to suit filter lag
`timescale 1ns/1ps
module isp_slave_port_bench
  import isp_pkg::*;
;
  localparam int TIMEOUT_CYC = 40000;
  logic        clk_sys;
  logic        rst;
  logic        sclLine;
  logic        sdaDrv;
  logic        sdaLine;
  logic        sdaOut;
  logic        sdaOeN;
  isp_wr_s     regWr;
  logic [7:0]  regAddr;
  logic [7:0]  regRdData;
  logic        hsMode;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic [15:0] wrQ[$];
  logic [7:0]  rd;

  // pull-up wins unless either party pulls low
  assign sdaLine = sdaDrv & (sdaOeN | sdaOut);
  assign regRdData = regAddr ^ 8'h5A;

  isp_slave_port u_isp_slave_port (.clk_sys(clk_sys), .rst(rst), .sclIn(sclLine),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .regWr(regWr),
    .regAddr(regAddr), .regRdData(regRdData), .hsMode(hsMode));
  isp_bus_master u_isp_bus_master (.clk_sys(clk_sys), .sdaLine(sdaLine),
    .sclDrv(sclLine), .sdaDrv(sdaDrv));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (regWr.en === 1'b1) wrQ.push_back({regWr.addr, regWr.data});
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYC) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic sendChk(input logic [7:0] d, input logic expAck);
    logic a;
    u_isp_bus_master.sendByte(d, a);
    check({15'h0000, a}, {15'h0000, expAck});
  endtask
  task automatic popChk(input logic [15:0] exp);
    logic [15:0] v;
    v = 16'hXXXX;
    if (wrQ.size() > 0) v = wrQ.pop_front();
    check(v, exp);
  endtask

  task automatic testWrite();
    u_isp_bus_master.sendStart();
    sendChk(8'h30, 1'b1);
    sendChk(8'h02, 1'b1);
    sendChk(8'hA5, 1'b1);
    sendChk(8'h3C, 1'b1);
    u_isp_bus_master.sendStop();
    popChk(16'h02A5);
    popChk(16'h033C);
  endtask
  task automatic testRead();
    u_isp_bus_master.sendStart();
    sendChk(8'h30, 1'b1);
    sendChk(8'h04, 1'b1);
    u_isp_bus_master.sendStart();
    sendChk(8'h31, 1'b1);
    u_isp_bus_master.recvByte(1'b0, rd);
    check({8'h00, rd}, 16'h005E);
    u_isp_bus_master.recvByte(1'b1, rd);
    check({8'h00, rd}, 16'h005F);
    u_isp_bus_master.sendStop();
    check(16'(wrQ.size()), 16'h0000);
  endtask
  task automatic testRefuse();
    u_isp_bus_master.sendStart();
    sendChk(8'h32, 1'b0);
    sendChk(8'h55, 1'b0);
    u_isp_bus_master.sendStart();
    sendChk(8'h00, 1'b0);
    sendChk(8'h66, 1'b0);
    u_isp_bus_master.sendStop();
    check(16'(wrQ.size()), 16'h0000);
    u_isp_bus_master.sendStart();
    sendChk(8'h31, 1'b1);
    u_isp_bus_master.recvByte(1'b1, rd);
    check({8'h00, rd}, 16'h005C);
    u_isp_bus_master.sendStop();
  endtask
  task automatic testHs();
    for (int k = 0; k < 8; k++) begin
      u_isp_bus_master.sendStart();
      sendChk(8'h08 | 8'(k), 1'b0);
      check({15'h0000, hsMode}, 16'h0001);
      u_isp_bus_master.sendStop();
      repeat (30) @(posedge clk_sys);
      check({15'h0000, hsMode}, 16'h0000);
    end
    u_isp_bus_master.sendStart();
    sendChk(8'h09, 1'b0);
    u_isp_bus_master.sendStart();
    sendChk(8'h30, 1'b1);
    sendChk(8'h10, 1'b1);
    sendChk(8'h77, 1'b1);
    check({15'h0000, hsMode}, 16'h0001);
    u_isp_bus_master.sendStop();
    popChk(16'h1077);
  endtask

  initial begin
    rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check({6'h00, regWr.en, sdaOeN, regAddr}, 16'h0100);
    testWrite();
    testRead();
    testRefuse();
    testHs();
    print_verdict();
  end
endmodule

bind isp_slave_port isp_port_checker u_isp_port_checker (.clk_sys(clk_sys), .rst(rst),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .regWr(regWr),
  .regAddr(regAddr), .regRdData(regRdData), .hsMode(hsMode));
